// >>> rtc_pkg.sv
// Purpose: Shared constants, types and helpers of the offset correction block
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register access
// Notes: Time-of-day is kept in binary fields, not BCD
package rtc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam longint CLK_PERIOD_NS = 64'd10;
    localparam int TICK_HZ = 64;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    // Correction interrupt pulse, 1/128 s
    localparam longint IRQ_PULSE_NS = 64'd7_812_500;
    localparam int IRQ_PULSE_CYC = int'(IRQ_PULSE_NS / CLK_PERIOD_NS);
    localparam int PRESC_W = 6;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_OFFSET = 8'h04;
    localparam logic [7:0] OFS_TIME = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_CLEAR = 8'h10;
    localparam logic [7:0] OFS_ENABLE = 8'h14;
    localparam logic [7:0] OFS_DEBUG = 8'h18;

    localparam int CTRL_STOP_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam int CTRL_CIE_BIT = 2;
    localparam int OFFSET_MODE_BIT = 7;
    localparam int TOD_SEC_LSB = 0;
    localparam int TOD_MIN_LSB = 8;
    localparam int TOD_HOUR_LSB = 16;
    localparam int ST_SECOND_BIT = 0;
    localparam int ST_CORR_BIT = 1;
    localparam int ST_RUN_BIT = 2;
    localparam int DBG_REMAIN_LSB = 0;
    localparam int DBG_BURST_LSB = 8;
    localparam int DBG_PRESC_LSB = 16;

    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] ENABLE_RESET = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [5:0] LAST_SECOND = 6'h3b;
    localparam logic [5:0] LAST_MINUTE = 6'h3b;
    localparam logic [4:0] LAST_HOUR = 5'h17;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic correction_irq_enable;
        logic external_clock_test;
        logic stop;
    } ctrl_t;

    typedef struct packed {
        logic coarse;
        logic [6:0] value;
    } offset_t;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } tod_t;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b01,
        RUN_ACTIVE = 2'b10
    } run_state_t;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [6:0] magnitude(input logic [6:0] value);
        return value[6] ? 7'(-value) : value;
    endfunction

    function automatic logic [6:0] minute_pulses(input logic [6:0] remain,
                                                 input logic coarse,
                                                 input logic [5:0] minute);
        if (coarse && minute == LAST_MINUTE)
        begin
            return remain;
        end
        return (remain != 7'h00) ? 7'h01 : 7'h00;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// >>> rtc_prescaler.sv
// Purpose: 64 Hz base tick and 6-bit prescaler producing the 1 Hz tick
// Assumes: ext_edge_in is already synchronised to clk_in
// Notes: Correction steps act only on the prescaler, never on the base tick
`timescale 1ns/1ps
module rtc_prescaler #(
    parameter int TICK_DIV = rtc_pkg::TICK_DIV,
    parameter int PRESC_W = rtc_pkg::PRESC_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Control
    input wire logic stop_in,
    input wire logic external_clock_test_in,
    input wire logic ext_edge_in,
    input wire logic corr_add_in,
    input wire logic corr_drop_in,
    // Ticks
    output logic tick_out,
    output logic sec_tick_out,
    output logic [PRESC_W-1:0] presc_out
);
    localparam int DIV_W = $clog2(TICK_DIV);

    logic [DIV_W-1:0] div_ff;
    logic [DIV_W-1:0] nxt_div;
    logic tick_ff;
    logic nxt_tick;
    logic sec_tick_ff;
    logic nxt_sec_tick;
    logic [PRESC_W-1:0] presc_ff;
    logic [PRESC_W-1:0] nxt_presc;

    always_comb
    begin
        nxt_div = (div_ff == DIV_W'(TICK_DIV - 1)) ? '0 : div_ff + 1'b1;
        nxt_tick = external_clock_test_in ? ext_edge_in : (div_ff == DIV_W'(TICK_DIV - 1));
        nxt_presc = presc_ff;
        if (tick_ff)
        begin
            if (corr_drop_in)
            begin
                nxt_presc = presc_ff;
            end
            else if (corr_add_in)
            begin
                nxt_presc = presc_ff + PRESC_W'(2);
            end
            else
            begin
                nxt_presc = presc_ff + PRESC_W'(1);
            end
        end
        if (stop_in)
        begin
            nxt_presc = '0;
        end
        nxt_sec_tick = nxt_presc[PRESC_W-1] && !presc_ff[PRESC_W-1];
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            div_ff <= '0;
            tick_ff <= 1'b0;
            sec_tick_ff <= 1'b0;
            presc_ff <= '0;
        end
        else
        begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
            sec_tick_ff <= nxt_sec_tick;
            presc_ff <= nxt_presc;
        end
    end

    assign tick_out = tick_ff;
    assign sec_tick_out = sec_tick_ff;
    assign presc_out = presc_ff;
endmodule

// >>> rtc_offset_correction.sv
// Purpose: Offset correction engine, time-of-day and external clock test mode
// Assumes: AXI4-Lite master keeps one write and one read outstanding at most
// Notes: Correction interrupt pulse width is counted in system clock cycles
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Seven-bit offset read as two's complement
// - Correction adds or drops one 64 Hz step
// - Normal mode: run every two hours
// - Coarse mode: run every hour, 60 minutes
// - Coarse small value: one pulse per minute
// - Coarse large value: surplus lands minute 59
// - Enabled: 1/128 s low pulse per correction
// - Multiple pulses repeat every 1/64 s
// - Only 1 Hz path sees corrections
// - Test bit turns clock pin into input
// - Test mode: 64 edges per second
// - Stop holds prescaler at zero
// - After stop: first second at 32 edges
// - Test entry not synchronised, state undefined
module rtc_offset_correction #(
    parameter int TICK_DIV = rtc_pkg::TICK_DIV,
    parameter int IRQ_PULSE_CYC = rtc_pkg::IRQ_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Pins
    input wire logic clkout_in,
    output logic clkout_out,
    output logic clkout_oe_out,
    output logic int_n_out,
    output logic irq_out
);
    localparam int IRQ_W = $clog2(IRQ_PULSE_CYC + 1);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic aw_ff, nxt_aw, w_ff, nxt_w;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata, rd_word;
    logic rd_ok, wr_ok, do_write;

    rtc_pkg::ctrl_t ctrl_ff, nxt_ctrl;
    rtc_pkg::offset_t offset_ff, nxt_offset;
    rtc_pkg::tod_t tod_ff, nxt_tod;
    logic [2:0] status_ff, nxt_status, enable_ff, nxt_enable, events, clear_mask;
    logic irq_ff, nxt_irq;

    rtc_pkg::run_state_t run_state_ff, nxt_run_state, run_sel;
    logic [6:0] remain_ff, nxt_remain, burst_ff, nxt_burst, pulses;
    logic run_coarse_ff, nxt_run_coarse, run_insert_ff, nxt_run_insert;
    logic minute_start, start_now, consume;
    logic [IRQ_W-1:0] int_cnt_ff, nxt_int_cnt;
    logic int_n_ff, nxt_int_n, clkout_ff, nxt_clkout, clkout_oe_ff, nxt_clkout_oe;

    logic pin_meta_ff, pin_sync_ff, pin_prev_ff, ext_edge;
    logic tick, sec_tick;
    logic [rtc_pkg::PRESC_W-1:0] presc;

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
        end
        else
        begin
            pin_meta_ff <= clkout_in;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign ext_edge = ctrl_ff.external_clock_test && pin_sync_ff && !pin_prev_ff;

    // ************************************************************
    // Prescaler
    // ************************************************************
    rtc_prescaler #(
        .TICK_DIV(TICK_DIV),
        .PRESC_W(rtc_pkg::PRESC_W)
    ) u_prescaler (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .stop_in(ctrl_ff.stop),
        .external_clock_test_in(ctrl_ff.external_clock_test),
        .ext_edge_in(ext_edge),
        .corr_add_in(consume && run_insert_ff),
        .corr_drop_in(consume && !run_insert_ff),
        .tick_out(tick),
        .sec_tick_out(sec_tick),
        .presc_out(presc)
    );

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    always_comb
    begin
        rd_ok = 1'b1;
        case (s_axi_araddr_in)
            rtc_pkg::OFS_CONTROL: rd_word = {29'h0, ctrl_ff};
            rtc_pkg::OFS_OFFSET: rd_word = {24'h0, offset_ff};
            rtc_pkg::OFS_TIME: rd_word = {11'h0, tod_ff.hour, 2'h0, tod_ff.minute,
                                          2'h0, tod_ff.second};
            rtc_pkg::OFS_STATUS: rd_word = {29'h0, status_ff};
            rtc_pkg::OFS_CLEAR: rd_word = 32'h0;
            rtc_pkg::OFS_ENABLE: rd_word = {29'h0, enable_ff};
            rtc_pkg::OFS_DEBUG: rd_word = {10'h0, presc, 1'b0, burst_ff, 1'b0, remain_ff};
            default:
            begin
                rd_word = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
        case (awaddr_ff)
            rtc_pkg::OFS_CONTROL, rtc_pkg::OFS_OFFSET, rtc_pkg::OFS_TIME,
            rtc_pkg::OFS_CLEAR, rtc_pkg::OFS_ENABLE: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
        do_write = aw_ff && w_ff && !bvalid_ff;
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_awready = awready_ff;
        nxt_wready = wready_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_awvalid_in && awready_ff)
        begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_axi_awaddr_in;
            nxt_awready = 1'b0;
        end
        if (s_axi_wvalid_in && wready_ff)
        begin
            nxt_w = 1'b1;
            nxt_wdata = s_axi_wdata_in;
            nxt_wstrb = s_axi_wstrb_in;
            nxt_wready = 1'b0;
        end
        if (do_write)
        begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_ok ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
        end
        if (bvalid_ff && s_axi_bready_in)
        begin
            nxt_bvalid = 1'b0;
            nxt_awready = 1'b1;
            nxt_wready = 1'b1;
        end
        if (s_axi_arvalid_in && arready_ff)
        begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_word;
            nxt_rresp = rd_ok ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
        end
        if (rvalid_ff && s_axi_rready_in)
        begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= rtc_pkg::RESP_OKAY;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= rtc_pkg::RESP_OKAY;
        end
        else
        begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // ************************************************************
    // Control, time and correction engine
    // ************************************************************
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_offset = offset_ff;
        nxt_enable = enable_ff;
        nxt_tod = tod_ff;
        clear_mask = 3'h0;
        if (do_write && awaddr_ff == rtc_pkg::OFS_CONTROL)
        begin
            nxt_ctrl = rtc_pkg::ctrl_t'(rtc_pkg::merge({29'h0, ctrl_ff}, wdata_ff, wstrb_ff));
        end
        if (do_write && awaddr_ff == rtc_pkg::OFS_OFFSET)
        begin
            nxt_offset = rtc_pkg::offset_t'(rtc_pkg::merge({24'h0, offset_ff}, wdata_ff,
                                                            wstrb_ff));
        end
        if (do_write && awaddr_ff == rtc_pkg::OFS_ENABLE)
        begin
            nxt_enable = 3'(rtc_pkg::merge({29'h0, enable_ff}, wdata_ff, wstrb_ff));
        end
        if (do_write && awaddr_ff == rtc_pkg::OFS_CLEAR)
        begin
            clear_mask = 3'(rtc_pkg::merge(32'h0, wdata_ff, wstrb_ff));
        end

        // Time-of-day; a software write wins over the tick
        minute_start = 1'b0;
        if (do_write && awaddr_ff == rtc_pkg::OFS_TIME)
        begin
            nxt_tod = rtc_pkg::tod_t'({tod_ff.hour, tod_ff.minute, tod_ff.second});
            nxt_tod.second = wstrb_ff[0] ? wdata_ff[rtc_pkg::TOD_SEC_LSB +: 6] : tod_ff.second;
            nxt_tod.minute = wstrb_ff[1] ? wdata_ff[rtc_pkg::TOD_MIN_LSB +: 6] : tod_ff.minute;
            nxt_tod.hour = wstrb_ff[2] ? wdata_ff[rtc_pkg::TOD_HOUR_LSB +: 5] : tod_ff.hour;
        end
        else if (sec_tick)
        begin
            nxt_tod.second = tod_ff.second + 6'h01;
            if (tod_ff.second == rtc_pkg::LAST_SECOND)
            begin
                nxt_tod.second = 6'h00;
                minute_start = 1'b1;
                nxt_tod.minute = tod_ff.minute + 6'h01;
                if (tod_ff.minute == rtc_pkg::LAST_MINUTE)
                begin
                    nxt_tod.minute = 6'h00;
                    nxt_tod.hour = (tod_ff.hour == rtc_pkg::LAST_HOUR) ? 5'h00
                                                                        : tod_ff.hour + 5'h01;
                end
            end
        end

        // Pulse consumption, one per base tick
        // 1/64 s spacing
        consume = (burst_ff != 7'h00) && !ctrl_ff.stop;
        nxt_burst = (consume && tick) ? burst_ff - 7'h01 : burst_ff;
        nxt_remain = remain_ff;
        nxt_run_coarse = run_coarse_ff;
        nxt_run_insert = run_insert_ff;
        pulses = 7'h00;
        start_now = minute_start && nxt_tod.minute == 6'h00 &&
                    (offset_ff.coarse || !nxt_tod.hour[0]);
        if (start_now)
        begin
            nxt_remain = rtc_pkg::magnitude(offset_ff.value);
            nxt_run_coarse = offset_ff.coarse;
            nxt_run_insert = !offset_ff.value[6];
        end
        run_sel = start_now ? rtc_pkg::RUN_ACTIVE : run_state_ff;
        nxt_run_state = run_sel;
        case (run_sel)
            rtc_pkg::RUN_IDLE:
            begin
                nxt_run_state = rtc_pkg::RUN_IDLE;
            end
            rtc_pkg::RUN_ACTIVE:
            begin
                if (minute_start)
                begin
                    pulses = rtc_pkg::minute_pulses(nxt_remain, nxt_run_coarse,
                                                    nxt_tod.minute);
                    nxt_burst = nxt_burst + pulses;
                    nxt_remain = nxt_remain - pulses;
                    if (nxt_remain == 7'h00)
                    begin
                        nxt_run_state = rtc_pkg::RUN_IDLE;
                    end
                end
            end
            default:
            begin
                nxt_run_state = rtc_pkg::RUN_IDLE;
            end
        endcase

        nxt_int_cnt = (int_cnt_ff != '0) ? int_cnt_ff - 1'b1 : int_cnt_ff;
        if (consume && tick && ctrl_ff.correction_irq_enable)
        begin
            nxt_int_cnt = IRQ_W'(IRQ_PULSE_CYC);
        end
        nxt_int_n = (nxt_int_cnt == '0);

        // Sticky events; a set wins over a clear in the same cycle
        events = 3'h0;
        events[rtc_pkg::ST_SECOND_BIT] = sec_tick;
        events[rtc_pkg::ST_CORR_BIT] = consume && tick;
        events[rtc_pkg::ST_RUN_BIT] = start_now && (nxt_remain != 7'h00 || pulses != 7'h00);
        nxt_status = (status_ff & ~clear_mask) | events;
        nxt_irq = |(nxt_status & nxt_enable);

        nxt_clkout_oe = !nxt_ctrl.external_clock_test;
        nxt_clkout = !nxt_ctrl.external_clock_test && presc[rtc_pkg::PRESC_W-1];
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            ctrl_ff <= rtc_pkg::ctrl_t'(rtc_pkg::CTRL_RESET);
            offset_ff <= rtc_pkg::offset_t'(rtc_pkg::OFFSET_RESET);
            enable_ff <= rtc_pkg::ENABLE_RESET;
            status_ff <= rtc_pkg::STATUS_RESET;
            tod_ff <= '0;
            run_state_ff <= rtc_pkg::RUN_IDLE;
            remain_ff <= 7'h00;
            burst_ff <= 7'h00;
            run_coarse_ff <= 1'b0;
            run_insert_ff <= 1'b0;
            int_cnt_ff <= '0;
            int_n_ff <= 1'b1;
            irq_ff <= 1'b0;
            clkout_ff <= 1'b0;
            clkout_oe_ff <= 1'b1;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            offset_ff <= nxt_offset;
            enable_ff <= nxt_enable;
            status_ff <= nxt_status;
            tod_ff <= nxt_tod;
            run_state_ff <= nxt_run_state;
            remain_ff <= nxt_remain;
            burst_ff <= nxt_burst;
            run_coarse_ff <= nxt_run_coarse;
            run_insert_ff <= nxt_run_insert;
            int_cnt_ff <= nxt_int_cnt;
            int_n_ff <= nxt_int_n;
            irq_ff <= nxt_irq;
            clkout_ff <= nxt_clkout;
            clkout_oe_ff <= nxt_clkout_oe;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out = wready_ff;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign s_axi_rresp_out = rresp_ff;
    assign clkout_out = clkout_ff;
    assign clkout_oe_out = clkout_oe_ff;
    assign int_n_out = int_n_ff;
    assign irq_out = irq_ff;
endmodule

// >>> rtc_offset_correction_sva.sv
// Purpose: Port checker of the correction block
// Assumes: One clock domain
// Notes: Bound into the design below
`timescale 1ns/1ps
module rtc_offset_correction_sva #(parameter int IRQ_PULSE_CYC = 3) (
    // Watched ports
    input wire logic clk_in, reset_in, s_axi_awvalid_in, s_axi_awready_out,
    input wire logic s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in,
    input wire logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in,
    input wire logic clkout_out, clkout_oe_out, int_n_out
);
    logic [31:0] low_ff, nxt_low;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    always_comb nxt_low = int_n_out ? 32'h0 : low_ff + 32'h1;
    always_ff @(posedge clk_in) low_ff <= reset_in ? 32'h0 : nxt_low;
    chk_int_width: assert property ($rose(int_n_out) |-> low_ff == IRQ_PULSE_CYC)
        else $error("int pulse width");
    chk_int_bound: assert property (low_ff <= IRQ_PULSE_CYC) else $error("int pulse long");
    chk_pin_quiet: assert property (!clkout_oe_out |-> !clkout_out) else $error("pin driven");
    chk_aw_busy: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken while busy");
    chk_b_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("no write answer");
    chk_b_close: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out
        && s_axi_awready_out) else $error("write not closed");
    chk_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("no read answer");
    chk_r_close: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out
        && s_axi_arready_out) else $error("read not closed");
    cover property ($fell(int_n_out));
    cover property (!clkout_oe_out);
    cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule

bind rtc_offset_correction rtc_offset_correction_sva #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) u_sva (.*);

// >>> rtc_board_tester.sv
// Purpose: Board tester on the clock pin
// Assumes: Pin edges far slower than clk_in
// Notes: Pin follows the device while it drives
`timescale 1ns/1ps
module rtc_board_tester (
    // Clock and pin
    input wire logic clk_in,
    input wire logic oe_in,
    input wire logic dev_in,
    output logic pin_out
);
    logic lvl = 1'b0;
    assign pin_out = oe_in ? dev_in : lvl;
    task automatic send_edges(input int n);
        repeat (n)
        begin
            repeat (60) @(posedge clk_in);
            lvl <= 1'b1;
            repeat (40) @(posedge clk_in);
            lvl <= 1'b0;
        end
    endtask
endmodule

// >>> rtc_offset_correction_tb_top.sv
// Purpose: Self-checking bench of the correction block
// Assumes: Short tick divider
// Notes: Board tester clocks the pin in test mode
`timescale 1ns/1ps
module rtc_offset_correction_tb_top;
    typedef struct {logic [7:0] a; logic [31:0] d, e, r;} row_t;
    row_t rows[4] = '{'{8'h00, 32'h5, 32'h5, 32'h0}, '{8'h04, 32'hc0, 32'hc0, 32'h0},
        '{8'h10, 32'h7, 32'h0, 32'h0}, '{8'h1c, 32'h1, 32'h0, 32'h2}};
    logic clk_in = 1'b0, reset_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, got, resp;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, clkout_in, clkout_out, clkout_oe_out, int_n_out, irq_out;
    int bad_count = 0, checked = 0, falls = 0;
    rtc_offset_correction #(.TICK_DIV(8), .IRQ_PULSE_CYC(3)) u_rtc_offset_correction (.*);
    rtc_board_tester u_rtc_board_tester (.clk_in, .oe_in(clkout_oe_out), .dev_in(clkout_out),
        .pin_out(clkout_in));
    initial forever #5 clk_in = ~clk_in;
    always @(negedge int_n_out) falls++;
    task automatic chk(input string n, input logic [63:0] e, s);
        checked++;
        if (e !== s)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!s_axi_bvalid_out);
        resp = {30'h0, s_axi_bresp_out};
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (!s_axi_rvalid_out);
        got = s_axi_rdata_out;
        resp = {30'h0, s_axi_rresp_out};
    endtask
    task automatic print_verdict();
        $display("Checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        chk("pins", 64'h6, {61'h0, int_n_out, clkout_oe_out, irq_out});
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk("write resp", {32'h0, rows[i].r}, {32'h0, resp});
            rd(rows[i].a);
            chk("read", {rows[i].r, rows[i].e}, {resp, got});
        end
        wr(8'h00, 32'h3);
        wr(8'h00, 32'h6);
        chk("pin input", 64'h0, {62'h0, clkout_oe_out, clkout_out});
        wr(8'h04, 32'h82);
        wr(8'h14, 32'h2);
        wr(8'h08, 32'h3b3b);
        falls = 0;
        u_rtc_board_tester.send_edges(32);
        rd(8'h08);
        chk("time", {32'h0, 32'h10000}, {32'h0, got});
        u_rtc_board_tester.send_edges(16);
        chk("pulses", 64'h1, 64'(falls));
        rd(8'h0c);
        chk("status irq", {32'h7, 32'h1}, {got, 31'h0, irq_out});
        wr(8'h10, 32'h7);
        repeat (2) @(posedge clk_in);
        chk("irq clear", 64'h0, {63'h0, irq_out});
        u_rtc_board_tester.send_edges(46);
        rd(8'h08);
        chk("time early", 64'h10000, {32'h0, got});
        u_rtc_board_tester.send_edges(1);
        rd(8'h08);
        chk("time next", 64'h10001, {32'h0, got});
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        print_verdict();
    end
endmodule
